// ==== design/emt_merge.sv ====
// Bit-group merge of one source character into one destination character
module emt_merge
(
   // Source character
   input  wire logic [5:0] src_data_i,
   input  wire logic       src_wm_i,
   input  wire logic       src_im_i,
   // Destination character as read
   input  wire logic [5:0] dst_data_i,
   input  wire logic       dst_wm_i,
   input  wire logic       dst_im_i,
   // Group selects: data, word mark, item mark
   input  wire logic       sel_data_i,
   input  wire logic       sel_wm_i,
   input  wire logic       sel_im_i,
   // Merged character
   output logic [5:0]      out_data_o,
   output logic            out_wm_o,
   output logic            out_im_o
);
   // Unselected groups keep the destination bits untouched
   assign out_data_o = sel_data_i ? src_data_i : dst_data_i;
   assign out_wm_o   = sel_wm_i   ? src_wm_i   : dst_wm_i;
   assign out_im_o   = sel_im_i   ? src_im_i   : dst_im_i;
endmodule // emt_merge

// ==== design/emt_pkg.sv ====
// Constants and types shared by the extended move and translate unit
package emt_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_VARIANT = 8'h04;
   localparam logic [7:0] OFF_OPA     = 8'h08;
   localparam logic [7:0] OFF_OPB     = 8'h0c;
   localparam logic [7:0] OFF_ADDR_A  = 8'h10;
   localparam logic [7:0] OFF_BAR     = 8'h14;
   localparam logic [7:0] OFF_STATUS  = 8'h18;
   localparam logic [7:0] OFF_MODE    = 8'h1c;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_OP_BIT    = 1;
   localparam int CTRL_FORM_LSB  = 2;
   localparam int VAR_TV2_LSB    = 6;
   localparam int ST_BUSY_BIT    = 0;
   localparam int ST_DONE_BIT    = 1;
   localparam int ST_COUNT_LSB   = 16;

   // ----------------------------------------------------------------
   // Reset values and widths
   // ----------------------------------------------------------------
   localparam logic [18:0] ADDR_RST = 19'h00000;
   localparam logic [5:0]  VAR_RST  = 6'h00;
   localparam logic [1:0]  MODE_RST = 2'h1;
   localparam logic [15:0] CNT_RST  = 16'h0000;

   // Addressing modes: two, three and four character
   typedef enum logic [1:0] {
      MODE_TWO   = 2'b00,
      MODE_THREE = 2'b01,
      MODE_FOUR  = 2'b10
   } emt_mode_t;

   // Operand forms of the extended move
   typedef enum logic [1:0] {
      FORM_FULL = 2'b00,
      FORM_HELD = 2'b01,
      FORM_AONLY = 2'b10,
      FORM_NONE = 2'b11
   } emt_form_t;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SRC  = 3'b001,
      ST_TBL  = 3'b010,
      ST_DST  = 3'b011,
      ST_WR   = 3'b100
   } emt_state_t;
endpackage

// ==== design/emt_unit.sv ====
// Extended move and move-and-translate sequencer with APB registers
//
// Local design decisions: the APB register port and the placing of the registers.
module emt_unit
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Memory master
   output logic             mem_req_o,
   output logic             mem_we_o,
   output logic      [18:0] mem_addr_o,
   output logic      [5:0]  mem_wdata_o,
   output logic             mem_wwm_o,
   output logic             mem_wim_o,
   input  wire logic        mem_ack_i,
   input  wire logic [5:0]  mem_rdata_i,
   input  wire logic        mem_rwm_i,
   input  wire logic        mem_rim_i
);
   emt_pkg::emt_state_t state;
   logic [18:0] a_address_reg;
   logic [18:0] b_address_reg;
   logic [5:0]  variant;
   logic [18:0] op_a;
   logic [18:0] op_b;
   logic [11:0] op_var;
   logic [1:0]  mode;
   logic        op_xlate;
   logic        done;
   logic [15:0] count;
   logic [5:0]  src_d;
   logic        src_wm;
   logic        src_im;
   logic [5:0]  tbl_d;
   logic        tbl_wm;
   logic        tbl_im;
   logic [5:0]  dst_d;
   logic        dst_wm;
   logic        dst_im;
   logic [5:0]  mg_d;
   logic        mg_wm;
   logic        mg_im;
   logic        apb_wr;
   logic        apb_setup;
   logic        start;
   logic        wr_done;
   logic        stop;
   logic        dir_up;
   logic [2:0]  hi;
   logic [18:0] tbl_addr;
   logic        variant_data_select;
   logic        variant_wordmark_select;
   logic        variant_itemmark_select;

   // -------------------------------------------------------------------
   // Decode
   // -------------------------------------------------------------------
   assign apb_setup = psel_i && !penable_i && !pready_o;
   assign apb_wr    = psel_i && penable_i && pready_o && pwrite_i;
   assign start     = apb_wr && paddr_i == emt_pkg::OFF_CTRL
                      && pwdata_i[emt_pkg::CTRL_START_BIT]
                      && state == emt_pkg::ST_IDLE;
   assign wr_done   = state == emt_pkg::ST_WR && mem_req_o && mem_ack_i;
   assign hi        = variant[5:3];
   assign variant_data_select     = variant[0];
   assign variant_wordmark_select = variant[1];
   assign variant_itemmark_select = variant[2];
   // Odd high digit steps upward, translate always steps down
   assign dir_up    = !op_xlate && hi[0];

   // Stop test on the source and table characters of the step just written
   always_comb
   begin
      if (op_xlate)
         stop = src_wm || tbl_wm;
      else
         unique case (hi[2:1])
            2'b00: stop = 1'b1;
            2'b01: stop = src_wm;
            2'b10: stop = src_im;
            2'b11: stop = src_wm && src_im;
         endcase
   end

   // Table address: base from variants and A address, character in low bits
   always_comb
   begin
      if (mode == emt_pkg::MODE_FOUR)
         tbl_addr = {a_address_reg[18], op_var[5:0],
                     op_var[11:6], src_d};
      else
         tbl_addr = {a_address_reg[18:15], op_var[2:0],
                     op_var[11:6], src_d};
   end

   // Address step wrapping within bank, sector or whole memory
   function automatic logic [18:0] step(input logic [18:0] a,
                                        input logic up,
                                        input logic [1:0] m);
      logic [18:0] n;
      n = up ? a + 19'h00001 : a - 19'h00001;
      unique case (m)
         emt_pkg::MODE_TWO:   step = {a[18:12], n[11:0]};
         emt_pkg::MODE_THREE: step = {a[18:15], n[14:0]};
         default:             step = n;
      endcase
   endfunction

   // -------------------------------------------------------------------
   // Character merge
   // -------------------------------------------------------------------
   emt_merge emt_merge_i
   (
      .src_data_i (op_xlate ? tbl_d : src_d),
      .src_wm_i   (src_wm),
      .src_im_i   (op_xlate ? tbl_im : src_im),
      .dst_data_i (dst_d),
      .dst_wm_i   (dst_wm),
      .dst_im_i   (dst_im),
      .sel_data_i (op_xlate || variant_data_select),
      .sel_wm_i   (!op_xlate && variant_wordmark_select),
      .sel_im_i   (op_xlate || variant_itemmark_select),
      .out_data_o (mg_d),
      .out_wm_o   (mg_wm),
      .out_im_o   (mg_im)
   );

   // -------------------------------------------------------------------
   // APB slave
   // -------------------------------------------------------------------
   // One wait-free access phase; read data captured with pready
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
      end
      else
      begin
         pready_o  <= apb_setup;
         pslverr_o <= apb_setup && (paddr_i[1:0] != 2'b00
                      || paddr_i > emt_pkg::OFF_MODE);
         prdata_o  <= 32'h00000000;
         if (apb_setup)
            unique case (paddr_i)
               emt_pkg::OFF_VARIANT: prdata_o <= {20'h00000, op_var};
               emt_pkg::OFF_OPA:     prdata_o <= {13'h0000, op_a};
               emt_pkg::OFF_OPB:     prdata_o <= {13'h0000, op_b};
               emt_pkg::OFF_ADDR_A:
                  prdata_o <= {13'h0000, a_address_reg};
               emt_pkg::OFF_BAR:
                  prdata_o <= {13'h0000, b_address_reg};
               emt_pkg::OFF_STATUS:
                  prdata_o <= {count, 14'h0000, done,
                               state != emt_pkg::ST_IDLE};
               emt_pkg::OFF_MODE:    prdata_o <= {30'h00000000, mode};
               default:              prdata_o <= 32'h00000000;
            endcase
      end
   end

   // Operand staging and mode registers
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         op_a   <= emt_pkg::ADDR_RST;
         op_b   <= emt_pkg::ADDR_RST;
         op_var <= {emt_pkg::VAR_RST, emt_pkg::VAR_RST};
         mode   <= emt_pkg::MODE_RST;
      end
      else if (apb_wr)
         unique case (paddr_i)
            emt_pkg::OFF_OPA:     op_a   <= pwdata_i[18:0];
            emt_pkg::OFF_OPB:     op_b   <= pwdata_i[18:0];
            emt_pkg::OFF_VARIANT: op_var <= pwdata_i[11:0];
            emt_pkg::OFF_MODE:
               if (pwdata_i[1:0] != 2'b11)
                  mode <= pwdata_i[1:0];
            default: ;
         endcase
   end

   // Done flag: completion wins over a software clear
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         done <= 1'b0;
      else if (wr_done && stop)
         done <= 1'b1;
      else if (apb_wr && paddr_i == emt_pkg::OFF_STATUS
               && pwdata_i[emt_pkg::ST_DONE_BIT])
         done <= 1'b0;
   end

   // -------------------------------------------------------------------
   // Address, variant and count registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         a_address_reg <= emt_pkg::ADDR_RST;
         b_address_reg <= emt_pkg::ADDR_RST;
         variant       <= emt_pkg::VAR_RST;
         op_xlate      <= 1'b0;
         count         <= emt_pkg::CNT_RST;
      end
      else if (start)
      begin
         op_xlate <= pwdata_i[emt_pkg::CTRL_OP_BIT];
         count    <= emt_pkg::CNT_RST;
         if (pwdata_i[emt_pkg::CTRL_OP_BIT])
         begin
            a_address_reg <= op_a;
            b_address_reg <= op_b;
         end
         else
            unique case (pwdata_i[emt_pkg::CTRL_FORM_LSB +: 2])
               emt_pkg::FORM_FULL:
               begin
                  a_address_reg <= op_a;
                  b_address_reg <= op_b;
                  variant       <= op_var[5:0];
               end
               emt_pkg::FORM_HELD:
               begin
                  a_address_reg <= op_a;
                  b_address_reg <= op_b;
               end
               emt_pkg::FORM_AONLY: a_address_reg <= op_a;
               emt_pkg::FORM_NONE:  ;
            endcase
      end
      else if (state == emt_pkg::ST_IDLE && apb_wr)
      begin
         if (paddr_i == emt_pkg::OFF_ADDR_A)
            a_address_reg <= pwdata_i[18:0];
         if (paddr_i == emt_pkg::OFF_BAR)
            b_address_reg <= pwdata_i[18:0];
      end
      else if (wr_done)
      begin
         a_address_reg <= step(a_address_reg, dir_up, mode);
         b_address_reg <= step(b_address_reg, dir_up, mode);
         count         <= count + 16'h0001;
         if (op_xlate)
            variant <= tbl_d;
      end
   end

   // -------------------------------------------------------------------
   // Sequencer and memory port
   // -------------------------------------------------------------------
   // Each access raises mem_req_o and holds it until mem_ack_i
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         state       <= emt_pkg::ST_IDLE;
         mem_req_o   <= 1'b0;
         mem_we_o    <= 1'b0;
         mem_addr_o  <= emt_pkg::ADDR_RST;
         mem_wdata_o <= 6'h00;
         mem_wwm_o   <= 1'b0;
         mem_wim_o   <= 1'b0;
         src_d  <= 6'h00;
         src_wm <= 1'b0;
         src_im <= 1'b0;
         tbl_d  <= 6'h00;
         tbl_wm <= 1'b0;
         tbl_im <= 1'b0;
         dst_d  <= 6'h00;
         dst_wm <= 1'b0;
         dst_im <= 1'b0;
      end
      else if (state == emt_pkg::ST_IDLE)
      begin
         if (start)
            state <= emt_pkg::ST_SRC;
      end
      else if (!mem_req_o)
      begin
         mem_req_o <= 1'b1;
         mem_we_o  <= state == emt_pkg::ST_WR;
         unique case (state)
            emt_pkg::ST_SRC: mem_addr_o <= a_address_reg;
            emt_pkg::ST_TBL: mem_addr_o <= tbl_addr;
            default:         mem_addr_o <= b_address_reg;
         endcase
         mem_wdata_o <= mg_d;
         mem_wwm_o   <= mg_wm;
         mem_wim_o   <= mg_im;
      end
      else if (mem_ack_i)
      begin
         mem_req_o <= 1'b0;
         mem_we_o  <= 1'b0;
         unique case (state)
            emt_pkg::ST_SRC:
            begin
               src_d  <= mem_rdata_i;
               src_wm <= mem_rwm_i;
               src_im <= mem_rim_i;
               state  <= op_xlate ? emt_pkg::ST_TBL : emt_pkg::ST_DST;
            end
            emt_pkg::ST_TBL:
            begin
               tbl_d  <= mem_rdata_i;
               tbl_wm <= mem_rwm_i;
               tbl_im <= mem_rim_i;
               state  <= emt_pkg::ST_DST;
            end
            emt_pkg::ST_DST:
            begin
               dst_d  <= mem_rdata_i;
               dst_wm <= mem_rwm_i;
               dst_im <= mem_rim_i;
               state  <= emt_pkg::ST_WR;
            end
            default:
               state <= stop ? emt_pkg::ST_IDLE : emt_pkg::ST_SRC;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence s_write_issue;
      state == emt_pkg::ST_WR && mem_req_o && mem_we_o;
   endsequence

   sequence s_write_done;
      state == emt_pkg::ST_WR && mem_req_o && mem_ack_i;
   endsequence

   a_apb_ready_once: assert property (apb_setup |=> pready_o ##1 !pready_o)
      else $error("APB ready not a single cycle after setup");
   a_req_held: assert property (mem_req_o && !mem_ack_i |=>
                                mem_req_o && $stable(mem_addr_o))
      else $error("Memory request dropped or moved before ack");
   a_ext_groups: assert property ((s_write_issue and !op_xlate) |->
      mem_wdata_o == (variant[0] ? src_d : dst_d)
      && mem_wwm_o == (variant[1] ? src_wm : dst_wm)
      && mem_wim_o == (variant[2] ? src_im : dst_im))
      else $error("Extended move wrote wrong bit groups");
   a_xlate_marks: assert property ((s_write_issue and op_xlate) |->
      mem_wwm_o == dst_wm && mem_wdata_o == tbl_d
      && mem_wim_o == tbl_im)
      else $error("Translate write did not take table or keep word mark");
   a_single_stop: assert property ((s_write_done and (!op_xlate
      && hi[2:1] == 2'b00)) |=> state == emt_pkg::ST_IDLE && done)
      else $error("Single-character move did not end");
   a_mark_stop: assert property ((s_write_done and (op_xlate && src_wm))
      |=> state == emt_pkg::ST_IDLE)
      else $error("Translate ran past word-marked source");
   a_tbl_low: assert property (state == emt_pkg::ST_TBL && mem_req_o
      |-> mem_addr_o[11:0] == {op_var[11:6], src_d})
      else $error("Table address low part wrong");
   a_tbl_sector: assert property (state == emt_pkg::ST_TBL && mem_req_o
      && mode != emt_pkg::MODE_FOUR
      |-> mem_addr_o[18:15] == a_address_reg[18:15])
      else $error("Sector bits not taken from A address");
   a_xlate_down: assert property ((s_write_done and (op_xlate
      && mode == emt_pkg::MODE_FOUR))
      |=> a_address_reg == $past(a_address_reg) - 19'h00001)
      else $error("Translate did not step A address down");
   a_start_reads: assert property (start |=> state == emt_pkg::ST_SRC
      ##1 mem_req_o && !mem_we_o && mem_addr_o == a_address_reg)
      else $error("Start did not read the source");
endmodule // emt_unit

// ==== tb/emt_mem_model.sv ====
// Behavioural main memory answering the unit's character requests
module emt_mem_model
(
   // Clock
   input  wire logic        clk_i,
   // Request from the unit
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [18:0] addr_i,
   input  wire logic [5:0]  wdata_i,
   input  wire logic        wwm_i,
   input  wire logic        wim_i,
   // Answer to the unit
   output logic             ack_o,
   output logic [5:0]       rdata_o,
   output logic             rwm_o,
   output logic             rim_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Each location: item mark, word mark, six data bits
   bit [7:0] mem [int];
   int       wt;

   initial
   begin
      ack_o = 1'b0;
      {rim_o, rwm_o, rdata_o} = 8'h55;
      wt = 0;
   end

   // Answer after a random wait; read lines toggle when not answering
   always @(posedge clk_i)
   begin
      ack_o <= 1'b0;
      {rim_o, rwm_o, rdata_o} <= ~{rim_o, rwm_o, rdata_o};
      if (req_i && ack_o && we_i)
         mem[addr_i] = {wim_i, wwm_i, wdata_i};
      else if (req_i && !ack_o)
      begin
         if (wt == 0)
         begin
            ack_o <= 1'b1;
            {rim_o, rwm_o, rdata_o} <= mem.exists(addr_i) ? mem[addr_i]
                                                          : 8'h00;
            wt = $urandom % 3;
         end
         else
            wt = wt - 1;
      end
   end
endmodule // emt_mem_model

// ==== tb/extended_move_translate_unit_tb_top.sv ====
// Self-checking bench for the extended move and translate unit
module extended_move_translate_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i, reset_i, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        req, we, ack, wwm, wim, rwm, rim;
   logic [18:0] addr, a, b;
   logic [5:0]  wd, rdat, vhi, vlo, ch;
   logic [33:0] expq [$];
   logic [33:0] ew;
   bit   [7:0]  sv [5], dv [5], tv [4];
   int          n_mismatch, cmp_count, len, dr, n, s, d;

   emt_unit emt_unit_i
   (
      .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .mem_req_o(req), .mem_we_o(we), .mem_addr_o(addr), .mem_wdata_o(wd),
      .mem_wwm_o(wwm), .mem_wim_o(wim), .mem_ack_i(ack),
      .mem_rdata_i(rdat), .mem_rwm_i(rwm), .mem_rim_i(rim)
   );

   emt_mem_model emt_mem_model_i
   (
      .clk_i(clk_i), .req_i(req), .we_i(we), .addr_i(addr), .wdata_i(wd),
      .wwm_i(wwm), .wim_i(wim), .ack_o(ack), .rdata_o(rdat), .rwm_o(rwm),
      .rim_o(rim)
   );

   // 40 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [32:0] e,
                      input logic [32:0] v);
      cmp_count++;
      if (v !== e)
      begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, e, v);
      end
   endtask

   task automatic mset(input int ad, input bit [7:0] v);
      emt_mem_model_i.mem[ad] = v;
   endtask

   function automatic bit [7:0] mget(input int ad);
      return emt_mem_model_i.mem[ad];
   endfunction

   // Selected groups from the source, others from the destination
   function automatic bit [7:0] mrg(input bit [7:0] sc, input bit [7:0] dc,
                                    input int l);
      bit [7:0] m;
      m = {l[2], l[1], {6{l[0]}}};
      return (sc & m) | (dc & ~m);
   endfunction

   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic [7:0] ad, input logic w,
                      input logic [31:0] wdat);
      int k;
      @(posedge clk_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= ad;
      pwrite  <= w;
      pwdata  <= wdat;
      @(posedge clk_i);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      q = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k == 20)
      begin
         n_mismatch++;
         end_sim();
      end
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] wdat);
      apb(ad, 1'b1, wdat);
   endtask

   task automatic rdc(input logic [7:0] ad, input logic [32:0] e);
      expq.push_back({1'b1, e});
      apb(ad, 1'b0, 32'h0);
   endtask

   task automatic setup(input int sa, input int da, input logic [11:0] v);
      wr(emt_pkg::OFF_OPA, 32'(sa));
      wr(emt_pkg::OFF_OPB, 32'(da));
      wr(emt_pkg::OFF_VARIANT, 32'(v));
   endtask

   // Start an operation, poll done under a bound, then clear done
   task automatic go(input logic [31:0] c);
      int k;
      wr(emt_pkg::OFF_CTRL, c);
      k = 0;
      do
      begin
         expq.push_back(34'h0);
         apb(emt_pkg::OFF_STATUS, 1'b0, 32'h0);
         k++;
      end
      while (q[emt_pkg::ST_DONE_BIT] !== 1'b1 && k < 100);
      if (k == 100)
      begin
         n_mismatch++;
         end_sim();
      end
      wr(emt_pkg::OFF_STATUS, 32'h2);
   endtask

   // Read results are compared against the oldest note
   always @(posedge clk_i)
      if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
      begin
         ew = expq.pop_front();
         if (ew[33])
            chk("apb read", ew[32:0], {pslverr, prdata});
      end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      void'($urandom(32'h37a03860));
      {psel, penable, pwrite, paddr, pwdata} = '0;
      n_mismatch = 0;
      cmp_count = 0;
      reset_i = 1'b1;
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      // Reset values and an unmapped address
      rdc(emt_pkg::OFF_ADDR_A, 33'(emt_pkg::ADDR_RST));
      rdc(emt_pkg::OFF_MODE, 33'(emt_pkg::MODE_RST));
      rdc(emt_pkg::OFF_STATUS, 33'h0);
      rdc(8'h20, {1'b1, 32'h0});
      // Every direction/stop digit with every non-empty group selection
      for (int h = 0; h < 8; h++)
         for (int l = 1; l < 8; l++)
         begin
            len = h < 2 ? 1 : 1 + $urandom % 4;
            dr = h % 2 ? 1 : -1;
            for (int i = 0; i <= len; i++)
            begin
               sv[i] = ($urandom & 8'h3f) | (i == len - 1 ? (h / 2) << 6 : 0);
               dv[i] = $urandom;
               mset(300 + dr * i, sv[i]);
               mset(600 + dr * i, dv[i]);
            end
            setup(300, 600, {6'h00, 3'(h), 3'(l)});
            go(32'h1);
            for (int i = 0; i <= len; i++)
               chk("move", i < len ? mrg(sv[i], dv[i], l) : dv[i],
                   mget(600 + dr * i));
            rdc(emt_pkg::OFF_ADDR_A, 33'(300 + dr * len));
            rdc(emt_pkg::OFF_BAR, 33'(600 + dr * len));
            rdc(emt_pkg::OFF_STATUS, 33'(len) << 16);
         end
      // Short forms reuse held variant and addresses
      setup(100, 200, 12'o17);
      go(32'h1);
      for (int f = 3; f > 0; f--)
      begin
         s = f == 3 ? 101 : f == 2 ? 110 : 120;
         d = f == 1 ? 220 : 204 - f;
         sv[0] = $urandom;
         mset(s, sv[0]);
         mset(d, ~sv[0]);
         setup(f == 3 ? 900 : s, f == 1 ? d : 1000, 12'o01);
         go(32'(1 | f << 2));
         chk("short form", 33'(sv[0]), 33'(mget(d)));
         rdc(emt_pkg::OFF_ADDR_A, 33'(s + 1));
         rdc(emt_pkg::OFF_BAR, 33'(d + 1));
      end
      // Translate in two, three and four character mode, both stop kinds
      for (int md = 0; md < 3; md++)
         for (int k = 0; k < 2; k++)
         begin
            a = 19'h4a010;
            b = 19'h01200;
            vhi = 6'o75;
            vlo = $urandom;
            ch = $urandom;
            n = k ? 2 : 3;
            wr(emt_pkg::OFF_MODE, 32'(md));
            for (int i = 0; i < 4; i++)
            begin
               sv[i] = {2'b00, 6'(ch + i * 5)} | (i == 2 ? 8'h40 : 8'h00);
               tv[i] = ($urandom & 8'hbf) | (k && i == 1 ? 8'h40 : 8'h00);
               dv[i] = $urandom;
               mset(a - i, sv[i]);
               mset(b - i, dv[i]);
               if (md < 2)
                  mset({a[18:15], vhi[2:0], vlo, sv[i][5:0]}, tv[i]);
               else
                  mset({a[18], vhi, vlo, sv[i][5:0]}, tv[i]);
            end
            setup(a, b, {vlo, vhi});
            go(32'h3);
            for (int i = 0; i < 4; i++)
               chk("translate", i < n ? {tv[i][7], dv[i][6], tv[i][5:0]}
                   : dv[i], mget(b - i));
            rdc(emt_pkg::OFF_ADDR_A, 33'(a - n));
            rdc(emt_pkg::OFF_BAR, 33'(b - n));
         end
      end_sim();
   end
endmodule // extended_move_translate_unit_tb_top
